// file: design/scal_capture.v
// Contract
// - nonzero mode write selects type and arms; the code arms only for modes 1 and 2, and mode 3 takes no events
// - N-shot mode field self clears after capture
// - multiframe rate is clock over S times K
// - normal mode realigns divider, DDC, monitor, link
// - captured reference can mark a sample
// - transition select bit picks rising/falling level
// - capture edge select bit picks clock edge
// - N-shot discards up to 16 events first; the code discards at most 15 (skip count 15)
// - 4-bit skip count sets discarded events
// - continuous mode checks phase, resyncs on miss
// - skew window leaves dividers alone when inside
// - window negative bits 3:2, positive bits 1:0
// - negative before phase zero, positive after
// - status shows whether reference was captured
// - hold zero, setup low means setup error
// - setup zero, hold high means hold error
// - listed combinations mean no error
// - both zero means setup or hold error
// - timestamp mode keeps clocks, flags sample
// - marker needs function 5, honours delay
// - no timestamping while decimating
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "scal_defines.vh"

module scal_capture #(
	parameter SYNC_STAGES = 2
) (
	input  wire        mclk,
	input  wire        arst_n,
	input  wire [11:0] regAddr,
	input  wire [7:0]  regWdata,
	input  wire        regWr,
	input  wire        regRd,
	output reg  [7:0]  regRdata,
	input  wire        sysrefRise,
	input  wire        sysrefFall,
	input  wire [3:0]  setupCode,
	input  wire [3:0]  holdCode,
	input  wire        decimEnable,
	output reg         dividerSync,
	output reg         ddcSync,
	output reg         monitorSync,
	output reg         linkSync,
	output reg         sampleMark,
	output reg         lmfcTick
);

	// margin verdict from the status nibbles
	function [1:0] marginVerdict;
		input [3:0] hold;
		input [3:0] setup;
		begin
			if (hold == 4'h0 && setup == 4'h0)
				marginVerdict = `SCAL_VERDICT_EITHER;
			else if (hold == 4'h0 && setup <= 4'h7)
				marginVerdict = `SCAL_VERDICT_SETUP;
			else if (setup == 4'h0 && hold >= 4'h9)
				marginVerdict = `SCAL_VERDICT_HOLD;
			else
				marginVerdict = `SCAL_VERDICT_OK;
		end
	endfunction

	reg  [7:0]             control_reg;
	reg  [7:0]             skip_reg;
	reg  [7:0]             window_reg;
	reg  [7:0]             tsDelay_reg;
	reg  [7:0]             frameCfg_reg;
	reg  [7:0]             mframeCfg_reg;
	reg  [7:0]             ctrlFunc_reg;
	reg  [7:0]             syncMode_reg;
	reg  [7:0]             margin_reg;
	reg                    captured_reg;
	reg                    resyncSeen_reg;
	reg  [SYNC_STAGES-1:0] riseSync_reg;
	reg  [SYNC_STAGES-1:0] fallSync_reg;
	reg                    levelPrev_reg;
	reg                    prevValid_reg;
	reg  [4:0]             skipLeft_reg;
	reg                    armed_reg;
	reg  [8:0]             phase_reg;
	reg  [8:0]             tsCount_reg;
	reg                    tsPending_reg;

	wire [1:0] mode       = control_reg[`SCAL_CTL_MODE_HI:`SCAL_CTL_MODE_LO];
	wire       transSel   = control_reg[`SCAL_CTL_TRANS_BIT];
	wire       edgeSel    = control_reg[`SCAL_CTL_EDGE_BIT];
	wire [1:0] winNeg     = window_reg[`SCAL_WIN_NEG_HI:`SCAL_WIN_NEG_LO];
	wire [1:0] winPos     = window_reg[`SCAL_WIN_POS_HI:`SCAL_WIN_POS_LO];
	wire       tsMode     = syncMode_reg[0];
	wire       wrControl  = regWr && (regAddr == `SCAL_OFS_CONTROL);
	wire       modeActive = (mode == `SCAL_MODE_CONT) || (mode == `SCAL_MODE_NSHOT);

	// frame length S and multiframe length K, both stored minus one
	wire [8:0] mfLen      = {5'h00, frameCfg_reg[3:0]} + 9'h001;
	wire [8:0] kLen       = {4'h0, mframeCfg_reg[4:0]} + 9'h001;
	wire [17:0] periodW   = mfLen * kLen;
	wire [8:0] period     = periodW[8:0];
	wire [8:0] lastPhase  = period - 9'h001;

	// two-stage synchronisers; only the last stage is looked at
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			riseSync_reg <= {SYNC_STAGES{1'b0}};
			fallSync_reg <= {SYNC_STAGES{1'b0}};
		end else begin
			riseSync_reg <= {riseSync_reg[SYNC_STAGES-2:0], sysrefRise};
			fallSync_reg <= {fallSync_reg[SYNC_STAGES-2:0], sysrefFall};
		end
	end

	// sysrefFall is the level caught by the falling clock edge in the pad ring
	wire level     = edgeSel ? fallSync_reg[SYNC_STAGES-1] : riseSync_reg[SYNC_STAGES-1];
	wire riseEvt   = prevValid_reg && !levelPrev_reg && level;
	wire fallEvt   = prevValid_reg && levelPrev_reg && !level;
	wire qualEvt   = transSel ? fallEvt : riseEvt;
	wire seenEvt   = qualEvt && armed_reg && modeActive;

	// N-shot events are discarded until the skip count runs out
	wire skipping  = (mode == `SCAL_MODE_NSHOT) && (skipLeft_reg != 5'h00);
	wire takeEvt   = seenEvt && !skipping;

	// window compare: after phase zero counts up, before it counts back
	wire [8:0] preZero = period - phase_reg;
	wire inPos     = phase_reg <= {7'h00, winPos};
	wire inNeg     = (phase_reg != 9'h000) && (preZero <= {7'h00, winNeg});
	wire inWindow  = inPos || inNeg;

	// outside timestamp mode, N-shot captures and any capture while the captured flag is clear align; later ones only when outside
	wire contMiss  = (mode == `SCAL_MODE_CONT) && captured_reg && !inWindow;
	wire firstCap  = !captured_reg || (mode == `SCAL_MODE_NSHOT);
	wire realign   = takeEvt && !tsMode && (firstCap || contMiss);
	wire markEvt   = takeEvt && tsMode && !decimEnable
	               && (ctrlFunc_reg[2:0] == `SCAL_FUNC_MARKER);

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			levelPrev_reg <= 1'b0;
			prevValid_reg <= 1'b0;
		end else begin
			levelPrev_reg <= level;
			prevValid_reg <= 1'b1;
		end
	end

	// register writes; capture clear of the mode field loses to a new write
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			control_reg   <= `SCAL_RST_CONTROL;
			skip_reg      <= `SCAL_RST_SKIP;
			window_reg    <= `SCAL_RST_WINDOW;
			tsDelay_reg   <= `SCAL_RST_TS_DELAY;
			frameCfg_reg  <= `SCAL_RST_FRAME_CFG;
			mframeCfg_reg <= `SCAL_RST_MFRAME_CFG;
			ctrlFunc_reg  <= `SCAL_RST_CTRL_FUNC;
			syncMode_reg  <= `SCAL_RST_SYNC_MODE;
		end else begin
			if (wrControl) begin
				control_reg <= {3'h0, regWdata[4:0]} & 8'h1E;
			end else if (takeEvt && mode == `SCAL_MODE_NSHOT) begin
				control_reg[`SCAL_CTL_MODE_HI:`SCAL_CTL_MODE_LO] <= `SCAL_MODE_OFF;
			end
			if (regWr && regAddr == `SCAL_OFS_SKIP)
				skip_reg <= {4'h0, regWdata[3:0]};
			if (regWr && regAddr == `SCAL_OFS_WINDOW)
				window_reg <= {4'h0, regWdata[3:0]};
			if (regWr && regAddr == `SCAL_OFS_TS_DELAY)
				tsDelay_reg <= regWdata;
			if (regWr && regAddr == `SCAL_OFS_FRAME_CFG)
				frameCfg_reg <= {4'h0, regWdata[3:0]};
			if (regWr && regAddr == `SCAL_OFS_MFRAME_CFG)
				mframeCfg_reg <= {3'h0, regWdata[4:0]};
			if (regWr && regAddr == `SCAL_OFS_CTRL_FUNC)
				ctrlFunc_reg <= {5'h00, regWdata[2:0]};
			if (regWr && regAddr == `SCAL_OFS_SYNC_MODE)
				syncMode_reg <= {7'h00, regWdata[0]};
		end
	end

	// arming and the skip counter
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			armed_reg    <= 1'b0;
			skipLeft_reg <= 5'h00;
		end else if (wrControl) begin
			armed_reg    <= (regWdata[2:1] == `SCAL_MODE_CONT) || (regWdata[2:1] == `SCAL_MODE_NSHOT);
			skipLeft_reg <= {1'b0, skip_reg[3:0]};
		end else if (seenEvt && skipping) begin
			skipLeft_reg <= skipLeft_reg - 5'h01;
		end else if (takeEvt && mode == `SCAL_MODE_NSHOT) begin
			armed_reg    <= 1'b0;
		end
	end

	// local multiframe counter; a realign makes the event cycle phase zero
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			phase_reg <= 9'h000;
			lmfcTick  <= 1'b0;
		end else if (realign) begin
			phase_reg <= (period == 9'h001) ? 9'h000 : 9'h001;
			lmfcTick  <= 1'b1;
		end else if (phase_reg >= lastPhase) begin
			phase_reg <= 9'h000;
			lmfcTick  <= 1'b1;
		end else begin
			phase_reg <= phase_reg + 9'h001;
			lmfcTick  <= 1'b0;
		end
	end

	// synchronisation strobes, one cycle wide
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dividerSync <= 1'b0;
			ddcSync     <= 1'b0;
			monitorSync <= 1'b0;
			linkSync    <= 1'b0;
		end else begin
			dividerSync <= realign;
			ddcSync     <= realign;
			monitorSync <= realign;
			linkSync    <= realign;
		end
	end

	// marker delay; a new capture restarts the count
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tsCount_reg   <= 9'h000;
			tsPending_reg <= 1'b0;
			sampleMark    <= 1'b0;
		end else if (markEvt && tsDelay_reg == 8'h00) begin
			tsPending_reg <= 1'b0;
			sampleMark    <= 1'b1;
		end else if (markEvt) begin
			tsCount_reg   <= {1'b0, tsDelay_reg};
			tsPending_reg <= 1'b1;
			sampleMark    <= 1'b0;
		end else if (tsPending_reg && tsCount_reg == 9'h001) begin
			tsPending_reg <= 1'b0;
			sampleMark    <= 1'b1;
		end else begin
			if (tsPending_reg)
				tsCount_reg <= tsCount_reg - 9'h001;
			sampleMark <= 1'b0;
		end
	end

	// status: margin codes held from the last taken event
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			margin_reg <= 8'h00;
		end else if (takeEvt) begin
			margin_reg <= {holdCode, setupCode};
		end
	end

	// sticky event flags; set wins over a write-one clear
	wire clrEvents = regWr && (regAddr == `SCAL_OFS_EVENTS);

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			captured_reg   <= 1'b0;
			resyncSeen_reg <= 1'b0;
		end else begin
			if (takeEvt)
				captured_reg <= 1'b1;
			else if (clrEvents && regWdata[`SCAL_EVT_CAPTURED])
				captured_reg <= 1'b0;
			if (takeEvt && contMiss && !tsMode)
				resyncSeen_reg <= 1'b1;
			else if (clrEvents && regWdata[`SCAL_EVT_RESYNC])
				resyncSeen_reg <= 1'b0;
		end
	end

	// read port: data in the cycle after the strobe, zero otherwise
	reg [7:0] readMux;

	always @* begin
		readMux = 8'h00;
		case (regAddr)
			`SCAL_OFS_CONTROL:    readMux = control_reg;
			`SCAL_OFS_SKIP:       readMux = skip_reg;
			`SCAL_OFS_WINDOW:     readMux = window_reg;
			`SCAL_OFS_TS_DELAY:   readMux = tsDelay_reg;
			`SCAL_OFS_FRAME_CFG:  readMux = frameCfg_reg;
			`SCAL_OFS_MFRAME_CFG: readMux = mframeCfg_reg;
			`SCAL_OFS_CTRL_FUNC:  readMux = ctrlFunc_reg;
			`SCAL_OFS_SYNC_MODE:  readMux = syncMode_reg;
			`SCAL_OFS_MARGIN:     readMux = margin_reg;
			`SCAL_OFS_EVENTS:     readMux = {4'h0, marginVerdict(margin_reg[7:4], margin_reg[3:0]),
			                                 resyncSeen_reg, captured_reg};
			default:              readMux = 8'h00;
		endcase
	end

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			regRdata <= 8'h00;
		else if (regRd)
			regRdata <= readMux;
		else
			regRdata <= 8'h00;
	end

endmodule // scal_capture

// file: design/scal_defines.vh
`ifndef SCAL_DEFINES_VH
`define SCAL_DEFINES_VH

// register offsets
`define SCAL_OFS_CONTROL     12'h120
`define SCAL_OFS_SKIP        12'h121
`define SCAL_OFS_WINDOW      12'h122
`define SCAL_OFS_TS_DELAY    12'h123
`define SCAL_OFS_FRAME_CFG   12'h124
`define SCAL_OFS_MFRAME_CFG  12'h125
`define SCAL_OFS_CTRL_FUNC   12'h126
`define SCAL_OFS_MARGIN      12'h128
`define SCAL_OFS_EVENTS      12'h129
`define SCAL_OFS_SYNC_MODE   12'h1FF

// control register fields
`define SCAL_CTL_TRANS_BIT   4
`define SCAL_CTL_EDGE_BIT    3
`define SCAL_CTL_MODE_HI     2
`define SCAL_CTL_MODE_LO     1
`define SCAL_MODE_OFF        2'h0
`define SCAL_MODE_CONT       2'h1
`define SCAL_MODE_NSHOT      2'h2

// window register fields
`define SCAL_WIN_NEG_HI      3
`define SCAL_WIN_NEG_LO      2
`define SCAL_WIN_POS_HI      1
`define SCAL_WIN_POS_LO      0

// events register fields
`define SCAL_EVT_CAPTURED    0
`define SCAL_EVT_RESYNC      1
`define SCAL_EVT_VERDICT_LO  2
`define SCAL_EVT_VERDICT_HI  3

// margin verdict codes
`define SCAL_VERDICT_OK      2'h0
`define SCAL_VERDICT_SETUP   2'h1
`define SCAL_VERDICT_HOLD    2'h2
`define SCAL_VERDICT_EITHER  2'h3

// control bit function code for the reference marker
`define SCAL_FUNC_MARKER     3'h5

// reset values
`define SCAL_RST_CONTROL     8'h00
`define SCAL_RST_SKIP        8'h00
`define SCAL_RST_WINDOW      8'h00
`define SCAL_RST_TS_DELAY    8'h00
`define SCAL_RST_FRAME_CFG   8'h00
`define SCAL_RST_MFRAME_CFG  8'h1F
`define SCAL_RST_CTRL_FUNC   8'h00
`define SCAL_RST_SYNC_MODE   8'h00

`endif

// file: dv/scal_capture_props.sv
`timescale 1ns/1ps
module scal_capture_props #(
	parameter SYNC_STAGES = 2
) (
	input wire        mclk,
	input wire        arst_n,
	input wire [11:0] regAddr,
	input wire [7:0]  regWdata,
	input wire        regWr,
	input wire        regRd,
	input wire [7:0]  regRdata,
	input wire        sysrefRise,
	input wire        sysrefFall,
	input wire        decimEnable,
	input wire        dividerSync,
	input wire        ddcSync,
	input wire        monitorSync,
	input wire        linkSync,
	input wire        sampleMark
);
	reg  [7:0] riseHist_reg;
	reg  [7:0] fallHist_reg;
	wire [7:0] moved;
	wire       refMoved;
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			riseHist_reg <= 8'h00;
			fallHist_reg <= 8'h00;
		end else begin
			riseHist_reg <= {riseHist_reg[6:0], sysrefRise};
			fallHist_reg <= {fallHist_reg[6:0], sysrefFall};
		end
	end
	// a realign strobe must trace back to a level change a few edges earlier
	assign moved = (riseHist_reg ^ {riseHist_reg[6:0], 1'h0}) | (fallHist_reg ^ {fallHist_reg[6:0], 1'h0});
	assign refMoved = |moved[SYNC_STAGES+3:2];
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	sequence s_winWrRd;
		regWr && regAddr == 12'h122 ##2 regRd && regAddr == 12'h122;
	endsequence
	sequence s_ctlWrRd;
		regWr && regAddr == 12'h120 ##2 regRd && regAddr == 12'h120;
	endsequence
	property p_rdIdle;
		!$past(regRd) |-> regRdata == 8'h00;
	endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
	property p_unmapped;
		regRd && regAddr == 12'h127 |=> regRdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_winKeep;
		s_winWrRd |=> regRdata == ($past(regWdata, 3) & 8'h0F);
	endproperty
	a_winKeep: assert property (p_winKeep) else $error("window readback wrong");
	property p_ctlKeep;
		s_ctlWrRd |=> regRdata == ($past(regWdata, 3) & 8'h1E);
	endproperty
	a_ctlKeep: assert property (p_ctlKeep) else $error("control readback wrong");
	property p_syncAlike;
		dividerSync == ddcSync && ddcSync == monitorSync && monitorSync == linkSync;
	endproperty
	a_syncAlike: assert property (p_syncAlike) else $error("realign strobes differ");
	property p_syncCause;
		linkSync |-> refMoved;
	endproperty
	a_syncCause: assert property (p_syncCause) else $error("realign without reference edge");
	property p_markNoSync;
		sampleMark |-> !dividerSync;
	endproperty
	a_markNoSync: assert property (p_markNoSync) else $error("marker with realign");
	property p_decim;
		decimEnable && $past(decimEnable) |-> !sampleMark;
	endproperty
	a_decim: assert property (p_decim) else $error("marker while decimating");
endmodule // scal_capture_props

bind scal_capture scal_capture_props #(.SYNC_STAGES(SYNC_STAGES)) u_props (
	.mclk, .arst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .sysrefRise, .sysrefFall,
	.decimEnable, .dividerSync, .ddcSync, .monitorSync, .linkSync, .sampleMark
);

// file: dv/scal_ref_source.sv
`timescale 1ns/1ps
module scal_ref_source (
	input  wire       mclk,
	input  wire       fireReq,
	input  wire [7:0] period,
	input  wire [3:0] width,
	output reg        sysrefRise,
	output reg        sysrefFall
);
	reg [7:0] cnt_reg = 8'hFF;
	initial sysrefRise = 1'h0;
	initial sysrefFall = 1'h0;
	// one counter makes single shots and a periodic train
	always @(posedge mclk) begin
		if (fireReq || (period != 8'h00 && cnt_reg >= period - 8'h01))
			cnt_reg <= 8'h00;
		else if (cnt_reg != 8'hFF)
			cnt_reg <= cnt_reg + 8'h01;
		sysrefRise <= cnt_reg < {4'h0, width};
	end
	// falling clock capture sees the line half a cycle later
	always @(negedge mclk)
		sysrefFall <= sysrefRise;
endmodule // scal_ref_source

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	reg         mclk = 1'h0;
	reg         arst_n = 1'h0;
	reg  [11:0] regAddr = 12'h000;
	reg  [7:0]  regWdata = 8'h00;
	reg         regWr = 1'h0;
	reg         regRd = 1'h0;
	wire [7:0]  regRdata;
	wire        sysrefRise, sysrefFall, dividerSync, ddcSync, monitorSync, linkSync, sampleMark, lmfcTick;
	reg  [3:0]  setupCode = 4'h0;
	reg  [3:0]  holdCode = 4'h0;
	reg         decimEnable = 1'h0;
	reg         fireReq = 1'h0;
	reg  [7:0]  period = 8'h00;
	reg  [31:0] seed = 32'h5023CCA7;
	reg  [7:0]  v;
	reg  [3:0]  h, s;
	reg  [2:0]  sel;
	integer     err_count = 0;
	integer     checks_done = 0;
	integer     syncCnt = 0;
	integer     markCnt = 0;
	integer     i, k, base;
	integer     cyc = 0;
	integer     riseAt = 0;
	integer     markAt = 0;
	integer     tickAt = 0;
	integer     tickGap = 0;
	reg         riseLast = 1'h0;
	reg  [7:0]  dly;
	always #4 mclk = ~mclk;
	scal_capture u_dut (.mclk, .arst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .sysrefRise,
		.sysrefFall, .setupCode, .holdCode, .decimEnable, .dividerSync, .ddcSync, .monitorSync,
		.linkSync, .sampleMark, .lmfcTick);
	scal_ref_source u_src (.mclk, .fireReq, .period, .width(4'h8), .sysrefRise, .sysrefFall);
	// cycle stamps let the marker delay and multiframe spacing be measured
	always @(negedge mclk) begin
		cyc = cyc + 1;
		if (sysrefRise === 1'h1 && !riseLast)
			riseAt = cyc;
		riseLast = sysrefRise;
		if (dividerSync === 1'h1)
			syncCnt = syncCnt + 1;
		if (sampleMark === 1'h1) begin
			markCnt = markCnt + 1;
			markAt = cyc;
		end
		if (lmfcTick === 1'h1) begin
			tickGap = cyc - tickAt;
			tickAt = cyc;
		end
	end
	function [31:0] xs(input [31:0] a);
		reg [31:0] b;
		begin
			b = a ^ (a << 13);
			b = b ^ (b >> 17);
			xs = b ^ (b << 5);
		end
	endfunction
	function [1:0] verdict(input [3:0] hd, input [3:0] su);
		verdict = (hd == 4'h0 && su == 4'h0) ? 2'h3 : (hd == 4'h0 && su < 4'h8) ? 2'h1 :
			(su == 4'h0 && hd > 4'h8) ? 2'h2 : 2'h0;
	endfunction
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("mismatch %0s expected %0h seen %0h", nm, exp, seen);
			end
		end
	endtask
	task wr(input [11:0] a, input [7:0] d);
		begin
			@(posedge mclk);
			regAddr <= a;
			regWdata <= d;
			regWr <= 1'h1;
			@(posedge mclk);
			regWr <= 1'h0;
		end
	endtask
	task rd(input [11:0] a, output [7:0] d);
		begin
			@(posedge mclk);
			regAddr <= a;
			regRd <= 1'h1;
			@(posedge mclk);
			regRd <= 1'h0;
			@(negedge mclk);
			d = regRdata;
		end
	endtask
	task idle(input integer n);
		repeat (n) @(negedge mclk);
	endtask
	task fire;
		begin
			@(posedge mclk);
			fireReq <= 1'h1;
			@(posedge mclk);
			fireReq <= 1'h0;
			idle(20);
		end
	endtask
	task final_report;
		begin
			$display("checks %0d mismatches %0d", checks_done, err_count);
			if (err_count == 0 && checks_done > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	initial begin
		repeat (30000) @(posedge mclk);
		err_count = err_count + 1;
		final_report;
	end
	initial begin
		repeat (8) @(posedge mclk);
		arst_n <= 1'h1;
		wr(12'h127, 8'hFF);
		for (i = 0; i < 8; i = i + 1) begin
			rd(12'h120 + i[11:0], v);
			chk("reset", v, (i == 5) ? 8'h1F : 8'h00);
		end
		for (i = 0; i < 8; i = i + 1) begin
			seed = xs(seed);
			wr(12'h122, seed[7:0]);
			rd(12'h122, v);
			chk("window", v, seed[7:0] & 8'h0F);
			wr(12'h120, seed[15:8]);
			rd(12'h120, v);
			chk("control", v, seed[15:8] & 8'h1E);
		end
		wr(12'h120, 8'h00);
		fire;
		chk("off", syncCnt, 0);
		// every transition and capture edge pairing, with skip counts at the ends
		for (i = 0; i < 4; i = i + 1) begin
			k = (i == 2) ? 15 : (i == 0) ? 0 : 3;
			wr(12'h121, k[7:0]);
			wr(12'h120, {3'h0, i[1:0], 3'h4});
			base = syncCnt;
			repeat (k) fire;
			chk("skipped", syncCnt, base);
			seed = xs(seed);
			sel = seed[2:0] % 3'h5;
			h = (sel == 0) ? 4'h0 : (sel == 1) ? {1'h0, seed[10:8]} : (sel == 4) ? 4'h9 + seed[13:12] : 4'h8;
			s = (sel == 0) ? {1'h0, seed[10:8]} : (sel == 1) ? 4'h8 : (sel == 2) ? 4'h9 + seed[13:12] : 4'h0;
			@(posedge mclk);
			setupCode <= s;
			holdCode <= h;
			@(posedge mclk);
			fireReq <= 1'h1;
			@(posedge mclk);
			fireReq <= 1'h0;
			idle(9);
			chk("early", syncCnt, base + !i[1]);
			idle(10);
			chk("taken", syncCnt, base + 1);
			rd(12'h128, v);
			chk("margin", v, {h, s});
			rd(12'h129, v);
			chk("captured", v[0], 1);
			chk("verdict", v[3:2], verdict(h, s));
			rd(12'h120, v);
			chk("selfclear", v, {3'h0, i[1:0], 3'h0});
			fire;
			chk("disarmed", syncCnt, base + 1);
			wr(12'h129, 8'h03);
		end
		// multiframe of 8; periods 17 and 15 drift off it on purpose
		wr(12'h125, 8'h07);
		for (i = 0; i < 4; i = i + 1) begin
			k = (i == 0) ? 16 : (i == 3) ? 15 : 17;
			wr(12'h122, (i == 2) ? 8'h01 : (i == 3) ? 8'h04 : 8'h00);
			wr(12'h129, 8'h03);
			wr(12'h120, 8'h02);
			base = syncCnt;
			@(posedge mclk);
			period <= k[7:0];
			idle(12);
			chk("align", syncCnt, base + 1);
			idle(8 * k);
			chk("resync", syncCnt, base + ((i == 0) ? 1 : (i == 1) ? 9 : 5));
			@(posedge mclk);
			period <= 8'h00;
			wr(12'h120, 8'h00);
			rd(12'h129, v);
			chk("resyncflag", v[1], i != 0);
			if (i == 0)
				chk("lmfc", tickGap, 8);
			idle(60);
		end
		wr(12'h1FF, 8'h01);
		wr(12'h121, 8'h00);
		for (i = 0; i < 4; i = i + 1) begin
			seed = xs(seed);
			dly = (i == 3) ? 8'h00 : {4'h0, seed[3:0]};
			@(posedge mclk);
			decimEnable <= (i == 2);
			wr(12'h123, dly);
			wr(12'h126, (i == 1) ? 8'h04 : 8'h05);
			wr(12'h120, 8'h04);
			base = markCnt;
			k = syncCnt;
			fire;
			idle(20);
			chk("marker", markCnt, base + (i == 0 || i == 3));
			if (i == 0 || i == 3)
				chk("delay", markAt - riseAt, 3 + dly);
			chk("noclock", syncCnt, k);
		end
		final_report;
	end
endmodule // testbench
